// [rtl/rsv_dual_filter.sv]
/*
  one redundant safety input: two channels, each synchronised and held
  for a fixed count before the filtered level changes.
  assumes active-high inputs sampled on clk.
*/
module rsv_dual_filter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic chanA,
  input wire logic chanB,
  output logic level,
  output logic mismatch
);

  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic [2:0] cntA_reg;
  logic [2:0] cntB_reg;
  logic fA_reg;
  logic fB_reg;

  // two-stage synchronisers, first stage read only by second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncA_reg <= 2'h0;
      syncB_reg <= 2'h0;
    end else begin
      syncA_reg <= {syncA_reg[0], chanA};
      syncB_reg <= {syncB_reg[0], chanB};
    end
  end

  // per-channel hold filter, glitches shorter than the count are ignored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cntA_reg <= 3'h0;
      cntB_reg <= 3'h0;
      fA_reg <= 1'b0;
      fB_reg <= 1'b0;
    end else begin
      if (syncA_reg[1] == fA_reg) begin
        cntA_reg <= 3'h0;
      end else if (cntA_reg == 3'(rsv_pkg::FILTER_CYCLES - 1)) begin
        cntA_reg <= 3'h0;
        fA_reg <= syncA_reg[1];
      end else begin
        cntA_reg <= cntA_reg + 3'h1;
      end
      if (syncB_reg[1] == fB_reg) begin
        cntB_reg <= 3'h0;
      end else if (cntB_reg == 3'(rsv_pkg::FILTER_CYCLES - 1)) begin
        cntB_reg <= 3'h0;
        fB_reg <= syncB_reg[1];
      end else begin
        cntB_reg <= cntB_reg + 3'h1;
      end
    end
  end

  // either channel active counts as active, so one stuck channel is safe
  assign level = fA_reg | fB_reg;
  assign mismatch = fA_reg ^ fB_reg;

endmodule : rsv_dual_filter

// [rtl/rsv_pkg.sv]
/*
  constants for the robot safety i/o supervisor: register map, reset values,
  filter and timing counts.
  assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
*/
package rsv_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RESPONSE_MS = 1200;
  localparam int RESPONSE_CYCLES = RESPONSE_MS * 1000 * CLK_MHZ;
  localparam int FILTER_CYCLES = 4;
  localparam int TOGGLE_WINDOW_MS = 100;
  localparam int TOGGLE_WINDOW_CYCLES = TOGGLE_WINDOW_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] TOGGLE_LIMIT = 8'h08;
  localparam int DECEL_US = 100;
  localparam int DECEL_CYCLES = DECEL_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ERROR = 4'h8;
  localparam logic [3:0] ADDR_COMMAND = 4'hc;

  // config fields
  localparam int CFG_AUTO_RESET = 0;
  localparam int CFG_VERIFY_SW = 1;
  localparam int CFG_ARMED = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h0;

  // command fields (move request is a written level, error clear is write one to act)
  localparam int CMD_MOVE_REQ = 0;
  localparam int CMD_CLR_ERROR = 1;

  // error flag fields
  localparam int ERR_TOGGLE = 0;
  localparam int ERR_CHANNEL = 1;

  // number of safety inputs
  localparam int NUM_IN = 8;
  localparam int IN_ESTOP = 0;
  localparam int IN_GUARD = 1;
  localparam int IN_REDUCED = 2;
  localparam int IN_GRESET = 3;
  localparam int IN_ENABLE = 4;
  localparam int IN_MODE_B = 5;
  localparam int IN_FORCE = 6;
  localparam int IN_SYSSTOP = 7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_DECEL, ST_GUARD_HOLD, ST_PAUSE, ST_ESTOP
  } rsv_state_e;

endpackage : rsv_pkg

// [rtl/rsv_supervisor.sv]
// What this block does
// - guard input active: halt motion, hold category 2 stop, power on
// - auto reset: resume alone once guard input clears
// - manual reset: stay stopped until guard reset input, then resume
// - auto or manual reset chosen by a software config bit
// - react to guard or reduced input within 1200 ms
// - flag an error when guard or reduced inputs toggle too often
// - reduced input active: enter reduced mode, clamp speed limits
// - reduced input inactive: leave reduced mode, normal limits
// - verification mode: motion only with enabling switch middle, except one run cycle when guard hold resumes
// - mode selector position A, software verify bit clear: normal unrestricted mode
// - selector position B: verification, pause when enable invalid
// - force control input active outside emergency state: enter force control mode
// - system stop input active: category 1 stop
// - system stop from another controller stops this one, one way
// - remain in emergency state while system stop input is active
// - normally-open emergency-stop output high in emergency state
// - moving output high while moving normally
// - not-stopping output high from stop acceptance until stopped or DECEL_CYCLES have passed
// - every safety input and the estop, moving and not-stopping outputs are two redundant channels
// - normally-closed emergency output is inverse of normally-open
/*
  top of the robot safety i/o supervisor: input filters, motion state
  machine, dual-channel safety outputs and an avalon-mm register slave.
  assumes a single 100 MHz clock, a synchronous active-low reset and an
  avalon master that holds its request until waitrequest is seen low.
*/
module rsv_supervisor #(
  parameter int TOGGLE_WIN = rsv_pkg::TOGGLE_WINDOW_CYCLES,
  parameter int RESP_LIMIT = rsv_pkg::RESPONSE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [7:0] safeInA,
  input wire logic [7:0] safeInB,
  input wire logic motionStopped,
  output logic [1:0] estopNoOut,
  output logic [1:0] estopNcOut,
  output logic [1:0] movingOut,
  output logic [1:0] notStoppingOut,
  output logic reducedLimitOut,
  output logic forceModeOut,
  output logic driveEnableOut,
  output logic driveHoldOut
);

  // -----------------------------------------------------------------
  // input filtering
  // -----------------------------------------------------------------
  logic [7:0] inLevel;
  logic [7:0] inMismatch;

  // one dual-channel filter per safety input
  genvar gi;
  generate
    for (gi = 0; gi < rsv_pkg::NUM_IN; gi++) begin : g_in
      rsv_dual_filter u_filt (
        .clk(clk),
        .rstn(rstn),
        .chanA(safeInA[gi]),
        .chanB(safeInB[gi]),
        .level(inLevel[gi]),
        .mismatch(inMismatch[gi])
      );
    end
  endgenerate

  logic guardIn;
  logic reducedIn;
  logic resetIn;
  logic enableOk;
  logic verifyMode;
  logic stopIn;
  assign guardIn = inLevel[rsv_pkg::IN_GUARD];
  assign reducedIn = inLevel[rsv_pkg::IN_REDUCED];
  assign resetIn = inLevel[rsv_pkg::IN_GRESET];
  assign enableOk = inLevel[rsv_pkg::IN_ENABLE];
  assign stopIn = inLevel[rsv_pkg::IN_SYSSTOP] | inLevel[rsv_pkg::IN_ESTOP];

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [2:0] config_reg;
  logic [1:0] error_reg;
  logic moveReq_reg;

  logic busWr;
  assign busWr = avsWrite && avsWaitRequest == 1'b0;

  // config word, software picks auto or manual reset before use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_reg <= rsv_pkg::CONFIG_RESET;
    end else if (busWr && avsAddress == rsv_pkg::ADDR_CONFIG
                 && avsByteEnable[0]) begin
      config_reg <= avsWriteData[2:0];
    end
  end

  // selector position B, or software verify bit, puts verification on
  assign verifyMode = inLevel[rsv_pkg::IN_MODE_B]
                      | config_reg[rsv_pkg::CFG_VERIFY_SW];

  // move request from software, a level held until cleared
  always_ff @(posedge clk) begin
    if (!rstn) begin
      moveReq_reg <= 1'b0;
    end else if (busWr && avsAddress == rsv_pkg::ADDR_COMMAND
                 && avsByteEnable[0]) begin
      moveReq_reg <= avsWriteData[rsv_pkg::CMD_MOVE_REQ];
    end
  end

  // -----------------------------------------------------------------
  // toggle rate monitor
  // -----------------------------------------------------------------
  logic guardDly_reg;
  logic reducedDly_reg;
  logic [31:0] winCnt_reg;
  logic [7:0] togCnt_reg;
  logic togEvent;
  logic togErr;
  assign togEvent = (guardIn ^ guardDly_reg) | (reducedIn ^ reducedDly_reg);
  // every edge from the limit on flags, so a cleared error comes back
  assign togErr = togEvent && togCnt_reg >= rsv_pkg::TOGGLE_LIMIT - 8'h01;

  // count edges on guard and reduced inputs inside a fixed window restarted every TOGGLE_WIN cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      guardDly_reg <= 1'b0;
      reducedDly_reg <= 1'b0;
      winCnt_reg <= 32'h0;
      togCnt_reg <= 8'h0;
    end else begin
      guardDly_reg <= guardIn;
      reducedDly_reg <= reducedIn;
      if (winCnt_reg == 32'(TOGGLE_WIN - 1)) begin
        winCnt_reg <= 32'h0;
        togCnt_reg <= 8'h0;
      end else begin
        winCnt_reg <= winCnt_reg + 32'h1;
        if (togEvent && togCnt_reg != rsv_pkg::TOGGLE_LIMIT) begin
          togCnt_reg <= togCnt_reg + 8'h1;
        end
      end
    end
  end

  // sticky error flags, a new event wins over a software clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      error_reg <= 2'h0;
    end else begin
      if (togErr) begin
        error_reg[rsv_pkg::ERR_TOGGLE] <= 1'b1;
      end else if (busWr && avsAddress == rsv_pkg::ADDR_COMMAND
                   && avsWriteData[rsv_pkg::CMD_CLR_ERROR]) begin
        error_reg[rsv_pkg::ERR_TOGGLE] <= 1'b0;
      end
      if (|inMismatch) begin
        error_reg[rsv_pkg::ERR_CHANNEL] <= 1'b1;
      end else if (busWr && avsAddress == rsv_pkg::ADDR_COMMAND
                   && avsWriteData[rsv_pkg::CMD_CLR_ERROR]) begin
        error_reg[rsv_pkg::ERR_CHANNEL] <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // motion state machine
  // -----------------------------------------------------------------
  rsv_pkg::rsv_state_e state_reg;
  rsv_pkg::rsv_state_e resume_reg;
  logic [13:0] decelCnt_reg;
  logic decelDone;
  assign decelDone = motionStopped
                     || decelCnt_reg == 14'(rsv_pkg::DECEL_CYCLES - 1);

  // decides stop, hold, pause and resume from the filtered inputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= rsv_pkg::ST_IDLE;
      resume_reg <= rsv_pkg::ST_IDLE;
      decelCnt_reg <= 14'h0;
    end else begin
      decelCnt_reg <= (state_reg == rsv_pkg::ST_DECEL)
                      ? decelCnt_reg + 14'h1 : 14'h0;
      unique case (state_reg)
        rsv_pkg::ST_IDLE, rsv_pkg::ST_RUN: begin
          if (stopIn) begin
            state_reg <= rsv_pkg::ST_DECEL;
            resume_reg <= rsv_pkg::ST_ESTOP;
          end else if (guardIn) begin
            state_reg <= rsv_pkg::ST_DECEL;
            resume_reg <= rsv_pkg::ST_GUARD_HOLD;
          end else if (verifyMode && !enableOk
                       && state_reg == rsv_pkg::ST_RUN) begin
            state_reg <= rsv_pkg::ST_PAUSE;
          end else if (moveReq_reg && config_reg[rsv_pkg::CFG_ARMED]
                       && (!verifyMode || enableOk)) begin
            state_reg <= rsv_pkg::ST_RUN;
          end else if (!moveReq_reg) begin
            state_reg <= rsv_pkg::ST_IDLE;
          end
        end
        rsv_pkg::ST_DECEL: begin
          if (stopIn) begin
            resume_reg <= rsv_pkg::ST_ESTOP;
          end
          if (decelDone) begin
            state_reg <= resume_reg;
          end
        end
        rsv_pkg::ST_GUARD_HOLD: begin
          if (stopIn) begin
            state_reg <= rsv_pkg::ST_ESTOP;
          end else if (!guardIn && config_reg[rsv_pkg::CFG_AUTO_RESET]) begin
            state_reg <= rsv_pkg::ST_RUN;
          end else if (!guardIn && resetIn) begin
            state_reg <= rsv_pkg::ST_RUN;
          end
        end
        rsv_pkg::ST_PAUSE: begin
          if (stopIn) begin
            state_reg <= rsv_pkg::ST_DECEL;
            resume_reg <= rsv_pkg::ST_ESTOP;
          end else if (guardIn) begin
            state_reg <= rsv_pkg::ST_GUARD_HOLD;
          end else if (!verifyMode || enableOk) begin
            state_reg <= rsv_pkg::ST_RUN;
          end
        end
        rsv_pkg::ST_ESTOP: begin
          if (!stopIn && resetIn) begin
            state_reg <= rsv_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= rsv_pkg::ST_ESTOP;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // safety outputs, both channels from flip-flops
  // -----------------------------------------------------------------
  logic inEstop;
  assign inEstop = state_reg == rsv_pkg::ST_ESTOP;

  // outputs follow the state and filtered inputs one edge later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      estopNoOut <= 2'h0;
      estopNcOut <= 2'h3;
      movingOut <= 2'h0;
      notStoppingOut <= 2'h0;
      reducedLimitOut <= 1'b0;
      forceModeOut <= 1'b0;
      driveEnableOut <= 1'b0;
      driveHoldOut <= 1'b0;
    end else begin
      estopNoOut <= {2{inEstop}};
      estopNcOut <= {2{!inEstop}};
      movingOut <= {2{state_reg == rsv_pkg::ST_RUN}};
      notStoppingOut <= {2{state_reg == rsv_pkg::ST_DECEL}};
      reducedLimitOut <= reducedIn;
      forceModeOut <= inLevel[rsv_pkg::IN_FORCE] && !inEstop;
      driveEnableOut <= !inEstop; // power stays on in guard stop
      driveHoldOut <= state_reg != rsv_pkg::ST_RUN;
    end
  end

  // -----------------------------------------------------------------
  // avalon-mm slave, every transfer answered one cycle after request
  // -----------------------------------------------------------------
  // waitrequest idles high from a flip-flop; a request seen while high
  // drops it for one cycle, in which writes land and read data stand
  always_ff @(posedge clk) begin
    if (!rstn) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0;
    end else begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      if (avsRead && avsWaitRequest) begin
        unique case (avsAddress)
          rsv_pkg::ADDR_CONFIG: avsReadData <= {29'h0, config_reg};
          rsv_pkg::ADDR_STATUS: avsReadData <= {16'h0, inLevel,
                                   1'b0, reducedLimitOut, forceModeOut,
                                   verifyMode, 1'b0, state_reg};
          rsv_pkg::ADDR_ERROR: avsReadData <= {30'h0, error_reg};
          rsv_pkg::ADDR_COMMAND: avsReadData <= {31'h0, moveReq_reg};
          default: avsReadData <= 32'h0;
        endcase
      end
    end
  end
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic [31:0] respCnt_reg;
  // counts cycles a guard request waits for motion to leave run
  always_ff @(posedge clk) begin
    if (!rstn) begin
      respCnt_reg <= 32'h0;
    end else if (guardIn && state_reg == rsv_pkg::ST_RUN) begin
      respCnt_reg <= respCnt_reg + 32'h1;
    end else begin
      respCnt_reg <= 32'h0;
    end
  end

  a_guard_response: assert property (
    @(posedge clk) disable iff (!rstn)
    respCnt_reg < 32'(RESP_LIMIT)) else $error("guard response too slow");
  a_nc_inverse: assert property (@(posedge clk) disable iff (!rstn)
    estopNcOut == ~estopNoOut) else $error("nc not inverse of no");
  a_estop_hold: assert property (@(posedge clk) disable iff (!rstn)
    inEstop && stopIn |=> inEstop) else $error("left estop early");
  a_estop_out: assert property (@(posedge clk) disable iff (!rstn)
    inEstop |=> estopNoOut == 2'h3) else $error("estop out missing");
  a_moving_out: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_reg == rsv_pkg::ST_RUN) |=> movingOut == 2'h3)
    else $error("moving out missing");
  a_guard_stop: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rsv_pkg::ST_RUN && guardIn && !stopIn
    |=> state_reg == rsv_pkg::ST_DECEL) else $error("guard not stopping");
  a_manual_wait: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rsv_pkg::ST_GUARD_HOLD && !resetIn
    && !config_reg[rsv_pkg::CFG_AUTO_RESET]
    |=> state_reg != rsv_pkg::ST_RUN) else $error("resumed without reset");
  a_reduced_out: assert property (@(posedge clk) disable iff (!rstn)
    reducedIn |=> reducedLimitOut) else $error("reduced limit missing");
  a_verify_pause: assert property (
    @(posedge clk) disable iff (!rstn)
    state_reg == rsv_pkg::ST_RUN && verifyMode && !enableOk && !guardIn
    && !stopIn |=> state_reg == rsv_pkg::ST_PAUSE)
    else $error("verify mode not paused");

endmodule : rsv_supervisor

// [tb/rsv_field_model.sv]
/*
  model of the external safety devices and of the motion planner that
  reports standstill.
  assumes the bench sets device levels just after a rising edge of clk.
*/
module rsv_field_model #(
  parameter int STOP_LAT = 20
) (
  input wire logic clk,
  input wire logic [7:0] level,
  input wire logic [7:0] skewB,
  input wire logic [1:0] movingOut,
  output logic [7:0] safeInA,
  output logic [7:0] safeInB,
  output logic motionStopped
);
  timeunit 1ns;
  timeprecision 1ps;
  int coast = 0;

  // ---------------------------------------------------------------
  // safety devices
  // ---------------------------------------------------------------
  // both channels follow the device; skew breaks channel b on purpose
  assign safeInA = level;
  assign safeInB = level ^ skewB;

  // ---------------------------------------------------------------
  // motion planner
  // ---------------------------------------------------------------
  // standstill only after a short coast once the arm stops moving
  initial motionStopped = 1'b1;
  always @(posedge clk) begin
    if (movingOut != 2'h0) begin
      coast <= 0;
      motionStopped <= 1'b0;
    end else if (coast < STOP_LAT) begin
      coast <= coast + 1;
    end else begin
      motionStopped <= 1'b1;
    end
  end
endmodule : rsv_field_model

// [tb/rsv_supervisor_bench.sv]
/*
  self-checking bench for the safety i/o supervisor: avalon tasks,
  input scenarios and expected values.
  assumes the supervisor top, and the field model in tb/.
*/
module rsv_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RESP = 200;
  localparam int SETTLE = 12;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [7:0] level = 8'h0;
  logic [7:0] skewB = 8'h0;
  logic [7:0] safeInA;
  logic [7:0] safeInB;
  logic motionStopped;
  logic [1:0] estopNoOut;
  logic [1:0] estopNcOut;
  logic [1:0] movingOut;
  logic [1:0] notStoppingOut;
  logic reducedLimitOut;
  logic forceModeOut;
  logic driveEnableOut;
  logic driveHoldOut;
  logic [31:0] rd;
  int numErrors = 0;
  int nCompared = 0;
  int stops [2];

  // ---------------------------------------------------------------
  // clock, design and field
  // ---------------------------------------------------------------
  // 100 mhz clock
  always #5 clk = ~clk;

  rsv_supervisor #(.TOGGLE_WIN(1000), .RESP_LIMIT(RESP)) DUT (
    .clk(clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .safeInA(safeInA), .safeInB(safeInB),
    .motionStopped(motionStopped), .estopNoOut(estopNoOut),
    .estopNcOut(estopNcOut), .movingOut(movingOut),
    .notStoppingOut(notStoppingOut), .reducedLimitOut(reducedLimitOut),
    .forceModeOut(forceModeOut), .driveEnableOut(driveEnableOut),
    .driveHoldOut(driveHoldOut));

  rsv_field_model field (
    .clk(clk), .level(level), .skewB(skewB), .movingOut(movingOut),
    .safeInA(safeInA), .safeInB(safeInB), .motionStopped(motionStopped));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finalReport();
    $display("checks %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finalReport

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [3:0] addr,
                      input logic [31:0] data);
    int n;
    n = 0;
    avsAddress <= addr;
    avsWriteData <= data;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
      rd = avsReadData;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      check("bus answer", 32'h0, 32'h1);
      finalReport();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    cycles(1);
  endtask : xfer

  task automatic readChk(input logic [3:0] addr, input logic [31:0] mask,
                         input logic [31:0] exp, input string what);
    xfer(1'b0, addr, 32'h0);
    check(what, exp, rd & mask);
  endtask : readChk

  task automatic stateChk(input logic [31:0] exp);
    readChk(rsv_pkg::ADDR_STATUS, 32'h7, exp, "state");
  endtask : stateChk

  task automatic setIn(input int b, input logic v);
    level[b] <= v;
    cycles(SETTLE);
  endtask : setIn

  task automatic pulse(input int b);
    setIn(b, 1'b1);
    setIn(b, 1'b0);
  endtask : pulse

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    stops[0] = rsv_pkg::IN_SYSSTOP;
    stops[1] = rsv_pkg::IN_ESTOP;
    cycles(20);
    check("estopNc", 32'h3, {30'h0, estopNcOut});
    check("moving", 32'h0, {30'h0, movingOut});
    rstn <= 1'b1;
    cycles(2);
    readChk(rsv_pkg::ADDR_CONFIG, 32'h7, 32'h0, "config");
    readChk(4'h2, 32'hffffffff, 32'h0, "unmapped");
    $display("test reset done");
    // armed, manual reset, move
    xfer(1'b1, rsv_pkg::ADDR_CONFIG, 32'h4);
    xfer(1'b1, rsv_pkg::ADDR_COMMAND, 32'h1);
    cycles(SETTLE);
    stateChk(32'h1);
    check("moving", 32'h3, {30'h0, movingOut});
    check("hold", 32'h0, {31'h0, driveHoldOut});
    // one-cycle glitch on the guard input is ignored
    level[rsv_pkg::IN_GUARD] <= 1'b1;
    cycles(1);
    level[rsv_pkg::IN_GUARD] <= 1'b0;
    cycles(SETTLE);
    stateChk(32'h1);
    $display("test run done");
    // guard stop, manual reset
    level[rsv_pkg::IN_GUARD] <= 1'b1;
    i = 0;
    while (movingOut !== 2'h0 && i < RESP) begin
      cycles(1);
      i++;
    end
    check("reaction", 32'h0, {30'h0, movingOut});
    cycles(2);
    check("notStop", 32'h3, {30'h0, notStoppingOut});
    cycles(40);
    check("notStop", 32'h0, {30'h0, notStoppingOut});
    check("drive", 32'h1, {31'h0, driveEnableOut});
    check("hold", 32'h1, {31'h0, driveHoldOut});
    stateChk(32'h3);
    setIn(rsv_pkg::IN_GUARD, 1'b0);
    stateChk(32'h3);
    pulse(rsv_pkg::IN_GRESET);
    stateChk(32'h1);
    // guard stop, auto reset
    xfer(1'b1, rsv_pkg::ADDR_CONFIG, 32'h5);
    setIn(rsv_pkg::IN_GUARD, 1'b1);
    cycles(40);
    stateChk(32'h3);
    setIn(rsv_pkg::IN_GUARD, 1'b0);
    stateChk(32'h1);
    $display("test guard done");
    // reduced and force modes
    setIn(rsv_pkg::IN_REDUCED, 1'b1);
    check("reduced", 32'h1, {31'h0, reducedLimitOut});
    readChk(rsv_pkg::ADDR_STATUS, 32'h40, 32'h40, "reduced");
    setIn(rsv_pkg::IN_REDUCED, 1'b0);
    check("reduced", 32'h0, {31'h0, reducedLimitOut});
    setIn(rsv_pkg::IN_FORCE, 1'b1);
    check("force", 32'h1, {31'h0, forceModeOut});
    setIn(rsv_pkg::IN_FORCE, 1'b0);
    check("force", 32'h0, {31'h0, forceModeOut});
    $display("test modes done");
    // channel mismatch, then too many toggles
    xfer(1'b1, rsv_pkg::ADDR_COMMAND, 32'h3);
    skewB[rsv_pkg::IN_REDUCED] <= 1'b1;
    cycles(SETTLE);
    check("oneChan", 32'h1, {31'h0, reducedLimitOut});
    readChk(rsv_pkg::ADDR_ERROR, 32'h2, 32'h2, "mismatch");
    skewB <= 8'h0;
    cycles(SETTLE);
    xfer(1'b1, rsv_pkg::ADDR_COMMAND, 32'h3);
    readChk(rsv_pkg::ADDR_ERROR, 32'h3, 32'h0, "cleared");
    for (i = 0; i < 10; i++) begin
      setIn(rsv_pkg::IN_REDUCED, ~i[0]);
    end
    readChk(rsv_pkg::ADDR_ERROR, 32'h1, 32'h1, "toggles");
    xfer(1'b1, rsv_pkg::ADDR_COMMAND, 32'h3);
    $display("test errors done");
    // verification mode by selector
    setIn(rsv_pkg::IN_ENABLE, 1'b1);
    setIn(rsv_pkg::IN_MODE_B, 1'b1);
    readChk(rsv_pkg::ADDR_STATUS, 32'h17, 32'h11, "verify");
    setIn(rsv_pkg::IN_ENABLE, 1'b0);
    readChk(rsv_pkg::ADDR_STATUS, 32'h17, 32'h14, "pause");
    check("moving", 32'h0, {30'h0, movingOut});
    setIn(rsv_pkg::IN_MODE_B, 1'b0);
    readChk(rsv_pkg::ADDR_STATUS, 32'h10, 32'h0, "normal");
    $display("test verify done");
    // system stop and external emergency stop
    for (i = 0; i < 2; i++) begin
      setIn(stops[i], 1'b1);
      cycles(40);
      check("estopNo", 32'h3, {30'h0, estopNoOut});
      check("estopNc", 32'h0, {30'h0, estopNcOut});
      check("moving", 32'h0, {30'h0, movingOut});
      stateChk(32'h5);
      cycles(200);
      stateChk(32'h5);
      setIn(stops[i], 1'b0);
      stateChk(32'h5);
      pulse(rsv_pkg::IN_GRESET);
      check("estopNo", 32'h0, {30'h0, estopNoOut});
      check("estopNc", 32'h3, {30'h0, estopNcOut});
    end
    $display("test stops done");
    finalReport();
  end
endmodule : rsv_supervisor_bench
